// ### hdl/cas_pkg.sv
// Constants for the calibration area store: area codes, keywords, counts.
// Assumes keywords arrive as right-aligned ASCII, zero padded on the left.
package cas_pkg;

    typedef enum logic [2:0] {
        CAS_AREA_ACTIVE,
        CAS_AREA_PREV,
        CAS_AREA_THIRD,
        CAS_AREA_SHIPPED,
        CAS_AREA_REFERENCE,
        CAS_AREA_INITIAL
    } cas_area_t;

    localparam int CAS_NUM_AREAS   = 6;
    localparam int CAS_ENTRIES     = 16;
    localparam int CAS_WIDTH       = 16;
    localparam int CAS_FLASH_SLOTS = 32;
    localparam int CAS_KW_BITS     = 64;

    localparam logic [15:0] CAS_ENTRY_RESET = 16'h0000;
    localparam logic [15:0] CAS_USED_RESET  = 16'h0000;
    localparam logic [7:0]  CAS_LOWER_A     = 8'h61;
    localparam logic [7:0]  CAS_LOWER_Z     = 8'h7a;
    localparam logic [7:0]  CAS_CASE_BIT    = 8'h20;

    // Short and long keyword forms of each area
    localparam logic [63:0] CAS_KW_ACT_S = {32'h0, "WORK"};
    localparam logic [63:0] CAS_KW_ACT_L = {8'h0, "WORKING"};
    localparam logic [63:0] CAS_KW_PRV_S = {40'h0, "PRI"};
    localparam logic [63:0] CAS_KW_PRV_L = {24'h0, "PRIOR"};
    localparam logic [63:0] CAS_KW_THR_S = {40'h0, "OLD"};
    localparam logic [63:0] CAS_KW_THR_L = {16'h0, "OLDEST"};
    localparam logic [63:0] CAS_KW_SHP_S = {32'h0, "FACT"};
    localparam logic [63:0] CAS_KW_SHP_L = {8'h0, "FACTORY"};
    localparam logic [63:0] CAS_KW_REF_S = {32'h0, "MAST"};
    localparam logic [63:0] CAS_KW_REF_L = {16'h0, "MASTER"};
    localparam logic [63:0] CAS_KW_INI_S = {40'h0, "FIR"};
    localparam logic [63:0] CAS_KW_INI_L = {24'h0, "FIRST"};

endpackage : cas_pkg

// ### hdl/cas_kw_decode.sv
// Keyword decoder: maps an area keyword, either case, to an area code.
// Assumes a combinational user; the result is not registered here.
`timescale 1ns/1ns
module cas_kw_decode (
    input  wire logic [63:0]        i_kw,
    output cas_pkg::cas_area_t      o_area,
    output logic                    o_valid
);
    logic [63:0] upper;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_kw[i*8 +: 8] >= cas_pkg::CAS_LOWER_A &&
                i_kw[i*8 +: 8] <= cas_pkg::CAS_LOWER_Z) begin
                upper[i*8 +: 8] = i_kw[i*8 +: 8] & ~cas_pkg::CAS_CASE_BIT;
            end else begin
                upper[i*8 +: 8] = i_kw[i*8 +: 8];
            end
        end
    end

    always_comb begin
        o_valid = 1'b1;
        o_area  = cas_pkg::CAS_AREA_ACTIVE;
        if (upper == cas_pkg::CAS_KW_ACT_S || upper == cas_pkg::CAS_KW_ACT_L) begin
            o_area = cas_pkg::CAS_AREA_ACTIVE;
        end else if (upper == cas_pkg::CAS_KW_PRV_S ||
                     upper == cas_pkg::CAS_KW_PRV_L) begin
            o_area = cas_pkg::CAS_AREA_PREV;
        end else if (upper == cas_pkg::CAS_KW_THR_S ||
                     upper == cas_pkg::CAS_KW_THR_L) begin
            o_area = cas_pkg::CAS_AREA_THIRD;
        end else if (upper == cas_pkg::CAS_KW_SHP_S ||
                     upper == cas_pkg::CAS_KW_SHP_L) begin
            o_area = cas_pkg::CAS_AREA_SHIPPED;
        end else if (upper == cas_pkg::CAS_KW_REF_S ||
                     upper == cas_pkg::CAS_KW_REF_L) begin
            o_area = cas_pkg::CAS_AREA_REFERENCE;
        end else if (upper == cas_pkg::CAS_KW_INI_S ||
                     upper == cas_pkg::CAS_KW_INI_L) begin
            o_area = cas_pkg::CAS_AREA_INITIAL;
        end else begin
            o_valid = 1'b0;
        end
    end

endmodule : cas_kw_decode

// ### hdl/cas_store.sv
// Calibration area store: six tables, save with history, area copy.
// Assumes commands come from same-clock logic, at most one useful per cycle.
//
// Behaviour
// - Keep six areas: active through initial
// - Tables stay through flash compaction
// - Accept short or long area keywords
// - Copy whole source area into destination
// - Active area is the calibration in effect
// - Save writes new values into active
// - Save shifts active to previous, previous onward
// - Save drops oldest, fixed areas untouched
// - Copy into active rotates history first
`timescale 1ns/1ns
module cas_store #(
    parameter int ENTRIES = cas_pkg::CAS_ENTRIES,
    parameter int WIDTH   = cas_pkg::CAS_WIDTH,
    parameter int SLOTS   = cas_pkg::CAS_FLASH_SLOTS,
    parameter int AW      = $clog2(ENTRIES)
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_stage_wr,
    input  wire logic [AW-1:0]       i_stage_addr,
    input  wire logic [WIDTH-1:0]    i_stage_data,
    input  wire logic                i_cal_store_cmd,
    input  wire logic                i_copy_cmd,
    input  wire logic [63:0]         i_copy_src_kw,
    input  wire logic [63:0]         i_copy_dst_kw,
    input  wire logic                i_flash_compact_cmd,
    input  wire logic [AW-1:0]       i_act_addr,
    input  wire logic [2:0]          i_rd_area,
    input  wire logic [AW-1:0]       i_rd_addr,
    output logic [WIDTH-1:0]         o_active_data,
    output logic [WIDTH-1:0]         o_rd_data,
    output logic                     o_done,
    output logic                     o_err,
    output logic                     o_full,
    output logic [15:0]              o_slots_used
);
    localparam int NA = cas_pkg::CAS_NUM_AREAS;

    logic              rst_meta;
    logic              rst_sync;

    logic [WIDTH-1:0]  tbl       [NA][ENTRIES];
    logic [WIDTH-1:0]  next_tbl  [NA][ENTRIES];
    logic [WIDTH-1:0]  stage     [ENTRIES];
    logic [WIDTH-1:0]  next_stage[ENTRIES];
    logic [15:0]       next_slots_used;
    logic              next_done;
    logic              next_err;
    logic              next_full;
    logic [WIDTH-1:0]  next_active_data;
    logic [WIDTH-1:0]  next_rd_data;

    cas_pkg::cas_area_t src_area;
    cas_pkg::cas_area_t dst_area;
    logic               src_ok;
    logic               dst_ok;
    logic               room;
    logic               take_compact;
    logic               take_save;
    logic               take_copy;
    logic               copy_ok;
    logic               save_go;
    logic               copy_go;
    logic               rotate;
    logic               accepted;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    cas_kw_decode u_src_kw (
        .i_kw    (i_copy_src_kw),
        .o_area  (src_area),
        .o_valid (src_ok)
    );

    cas_kw_decode u_dst_kw (
        .i_kw    (i_copy_dst_kw),
        .o_area  (dst_area),
        .o_valid (dst_ok)
    );

    // Each save or copy burns one flash slot; only compaction frees them
    assign room = (o_slots_used < 16'(SLOTS));

    // Compaction wins over save, save over copy; the losers are dropped
    // silently, so a host must not stack commands it cares about
    always_comb begin
        take_compact = i_flash_compact_cmd;
        take_save    = i_cal_store_cmd && !i_flash_compact_cmd;
        take_copy    = i_copy_cmd && !i_cal_store_cmd
                       && !i_flash_compact_cmd;
        copy_ok      = src_ok && dst_ok && room;
        save_go      = take_save && room;
        copy_go      = take_copy && copy_ok;
        rotate       = save_go
                       || (copy_go && dst_area == cas_pkg::CAS_AREA_ACTIVE);
        accepted     = save_go || copy_go;
    end

    // Staging holds the values that the next save commits
    // A staging write in the save cycle lands after the save reads it
    always_comb begin
        next_stage = stage;
        if (i_stage_wr) begin
            next_stage[i_stage_addr] = i_stage_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            for (int e = 0; e < ENTRIES; e++) begin
                stage[e] <= WIDTH'(cas_pkg::CAS_ENTRY_RESET);
            end
        end else begin
            stage <= next_stage;
        end
    end

    // History shifts before active loads, so a copy from previous still
    // reads the old previous contents
    always_comb begin
        next_tbl = tbl;
        if (rotate) begin
            for (int e = 0; e < ENTRIES; e++) begin
                next_tbl[cas_pkg::CAS_AREA_THIRD][e] =
                    tbl[cas_pkg::CAS_AREA_PREV][e];
                next_tbl[cas_pkg::CAS_AREA_PREV][e] =
                    tbl[cas_pkg::CAS_AREA_ACTIVE][e];
            end
        end
        if (save_go) begin
            for (int e = 0; e < ENTRIES; e++) begin
                next_tbl[cas_pkg::CAS_AREA_ACTIVE][e] = stage[e];
            end
        end else if (copy_go) begin
            // Reference is not locked here; keeping it is up to the host
            for (int e = 0; e < ENTRIES; e++) begin
                next_tbl[dst_area][e] = tbl[src_area][e];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            for (int a = 0; a < NA; a++) begin
                for (int e = 0; e < ENTRIES; e++) begin
                    tbl[a][e] <= WIDTH'(cas_pkg::CAS_ENTRY_RESET);
                end
            end
        end else begin
            tbl <= next_tbl;
        end
    end

    // Slot count only rises between compactions; a full store refuses save and copy until compaction
    always_comb begin
        next_slots_used = o_slots_used;
        if (take_compact) begin
            next_slots_used = cas_pkg::CAS_USED_RESET;
        end else if (accepted) begin
            next_slots_used = o_slots_used + 16'h0001;
        end
        next_full = (next_slots_used >= 16'(SLOTS));
    end

    always_ff @(posedge i_core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            o_slots_used <= cas_pkg::CAS_USED_RESET;
            o_full       <= 1'b0;
        end else begin
            o_slots_used <= next_slots_used;
            o_full       <= next_full;
        end
    end

    // A refused save or copy changes nothing but raises the error pulse
    always_comb begin
        next_done = take_compact || accepted;
        next_err  = (take_save || take_copy) && !accepted;
    end

    always_ff @(posedge i_core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            o_done <= 1'b0;
            o_err  <= 1'b0;
        end else begin
            o_done <= next_done;
            o_err  <= next_err;
        end
    end

    // Readouts are registered, so they show the state before this edge
    always_comb begin
        next_active_data = tbl[cas_pkg::CAS_AREA_ACTIVE][i_act_addr];
        if (i_rd_area < 3'(NA)) begin
            next_rd_data = tbl[i_rd_area][i_rd_addr];
        end else begin
            next_rd_data = '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            o_active_data <= '0;
            o_rd_data     <= '0;
        end else begin
            o_active_data <= next_active_data;
            o_rd_data     <= next_rd_data;
        end
    end

endmodule : cas_store

// ### bench/cas_store_chk.sv
// Checker: answer timing, slot count and active readout of the store.
// Assumes a bind onto cas_store; sees its ports only.
`timescale 1ns/1ns
module cas_store_chk #(
    parameter int SLOTS = 32,
    parameter int AW    = 4
) (
    input wire logic          i_core_clk,
    input wire logic          i_nrst,
    input wire logic          i_stage_wr,
    input wire logic [AW-1:0] i_stage_addr,
    input wire logic [15:0]   i_stage_data,
    input wire logic          i_cal_store_cmd,
    input wire logic          i_copy_cmd,
    input wire logic          i_flash_compact_cmd,
    input wire logic [AW-1:0] i_act_addr,
    input wire logic [15:0]   o_active_data,
    input wire logic          o_done,
    input wire logic          o_err,
    input wire logic [15:0]   o_slots_used
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_stage_act;
        i_stage_wr && i_stage_addr == i_act_addr;
    endsequence
    sequence s_save_ok;
        i_cal_store_cmd && !i_flash_compact_cmd && !i_stage_wr
            && o_slots_used < SLOTS && $stable(i_act_addr);
    endsequence
    a_save_active: assert property (s_stage_act ##1 s_save_ok
        ##1 $stable(i_act_addr) |=> o_active_data == $past(i_stage_data, 3))
        else $error("active data is not the staged value");
    a_save_count: assert property (s_save_ok |=> o_done
        && o_slots_used == $past(o_slots_used) + 16'h1)
        else $error("save not counted");
    a_save_refused: assert property (i_cal_store_cmd
        && !i_flash_compact_cmd && o_slots_used >= SLOTS
        |=> o_err && !o_done && $stable(o_slots_used))
        else $error("save taken while store full");
    a_compact_done: assert property (i_flash_compact_cmd
        |=> o_done && o_slots_used == 16'h0) else $error("compact failed");
    a_one_answer: assert property (!(o_done && o_err))
        else $error("done and error together");
    a_copy_answer: assert property (i_copy_cmd && !i_cal_store_cmd
        && !i_flash_compact_cmd |=> o_done != o_err)
        else $error("copy not answered");
    a_idle_quiet: assert property (!(i_cal_store_cmd || i_copy_cmd
        || i_flash_compact_cmd) |=> !o_done && !o_err
        && $stable(o_slots_used)) else $error("answer without command");
    a_active_hold: assert property ((!i_cal_store_cmd && !i_copy_cmd
        && $stable(i_act_addr)) [*2] |=> $stable(o_active_data))
        else $error("active data moved without command");
endmodule : cas_store_chk

// ### bench/cas_host.sv
// Host model: issues save, copy and compact commands to the store.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ns
module cas_host (
    input  wire logic   i_core_clk,
    output logic        o_save,
    output logic        o_copy,
    output logic        o_compact,
    output logic [63:0] o_src_kw,
    output logic [63:0] o_dst_kw
);
    localparam logic [63:0] KW [12] = '{cas_pkg::CAS_KW_ACT_S,
        cas_pkg::CAS_KW_ACT_L, cas_pkg::CAS_KW_PRV_S, cas_pkg::CAS_KW_PRV_L,
        cas_pkg::CAS_KW_THR_S, cas_pkg::CAS_KW_THR_L, cas_pkg::CAS_KW_SHP_S,
        cas_pkg::CAS_KW_SHP_L, cas_pkg::CAS_KW_REF_S, cas_pkg::CAS_KW_REF_L,
        cas_pkg::CAS_KW_INI_S, cas_pkg::CAS_KW_INI_L};
    // Codes above five give a keyword the store must refuse
    function automatic logic [63:0] kw(input logic [2:0] a, input bit l);
        return (a < 3'd6) ? KW[{a, l}] : 64'h0042_4f47_5553;
    endfunction : kw
    // Folds letters to lower case to exercise the case-blind compare
    function automatic logic [63:0] lower(input logic [63:0] k);
        logic [63:0] r;
        r = k;
        for (int i = 0; i < 8; i++) begin
            if (k[i*8 +: 8] >= 8'h41 && k[i*8 +: 8] <= 8'h5a) begin
                r[i*8 +: 8] = k[i*8 +: 8] | 8'h20;
            end
        end
        return r;
    endfunction : lower
    initial begin
        {o_save, o_copy, o_compact, o_src_kw, o_dst_kw} = '0;
    end
    task save;
        o_save <= 1'b1;
        @(posedge i_core_clk);
        o_save <= 1'b0;
    endtask : save
    task compact;
        o_compact <= 1'b1;
        @(posedge i_core_clk);
        o_compact <= 1'b0;
    endtask : compact
    // Released keywords are inverted so stale values never look valid
    task copy(input logic [2:0] s, input logic [2:0] d, input bit l,
              input bit lc);
        o_copy   <= 1'b1;
        o_src_kw <= lc ? lower(kw(s, l)) : kw(s, l);
        o_dst_kw <= kw((d == 3'd4) ? 3'd5 : d, !l);
        @(posedge i_core_clk);
        o_copy   <= 1'b0;
        o_src_kw <= ~o_src_kw;
        o_dst_kw <= ~o_dst_kw;
    endtask : copy
endmodule : cas_host

// ### bench/cas_store_tb_top.sv
// Testbench: saves, copies, full store and compaction against a model.
// Assumes cas_store, cas_host and the checker are compiled first.
`timescale 1ns/1ns
module cas_store_tb_top;
    localparam int SLOTS = 8;
    logic        clk, nrst, stage_wr, save, copy, compact, done, err, full;
    logic [3:0]  stage_addr, act_addr, rd_addr;
    logic [2:0]  rd_area;
    logic [15:0] stage_data, act_data, rd_data, slots_used;
    logic [63:0] src_kw, dst_kw;
    logic [15:0] mdl [6][16];
    logic [15:0] tmp [16];
    int          fails, checks, cyc, used;

    cas_store #(.SLOTS(SLOTS)) u_cas_store (.i_core_clk(clk),
        .i_nrst(nrst), .i_stage_wr(stage_wr), .i_stage_addr(stage_addr),
        .i_stage_data(stage_data), .i_cal_store_cmd(save),
        .i_copy_cmd(copy), .i_copy_src_kw(src_kw), .i_copy_dst_kw(dst_kw),
        .i_flash_compact_cmd(compact), .i_act_addr(act_addr),
        .i_rd_area(rd_area), .i_rd_addr(rd_addr), .o_active_data(act_data),
        .o_rd_data(rd_data), .o_done(done), .o_err(err), .o_full(full),
        .o_slots_used(slots_used));
    cas_host u_cas_host (.i_core_clk(clk), .o_save(save), .o_copy(copy),
        .o_compact(compact), .o_src_kw(src_kw), .o_dst_kw(dst_kw));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            print_verdict();
        end
    end

    task print_verdict;
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    function automatic bit accept(input bit kw_ok);
        return kw_ok && used < SLOTS;
    endfunction : accept
    task check_all;
        for (int a = 0; a < 6; a++) for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            rd_area <= a[2:0];
            rd_addr <= i[3:0];
            act_addr <= i[3:0];
            @(posedge clk);
            #1 cmp(rd_data, mdl[a][i]);
            cmp(act_data, mdl[0][i]);
        end
    endtask : check_all
    task answer(input bit ok);
        #1 cmp({15'h0, done}, {15'h0, ok});
        cmp({15'h0, err}, {15'h0, !ok});
        cmp(slots_used, used[15:0]);
        cmp({15'h0, full}, {15'h0, used >= SLOTS});
    endtask : answer
    task do_save;
        bit ok;
        ok = accept(1'b1);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            tmp[i] = 16'($urandom);
            stage_wr <= 1'b1;
            stage_addr <= i[3:0];
            stage_data <= tmp[i];
        end
        @(posedge clk);
        stage_wr <= 1'b0;
        u_cas_host.save();
        if (ok) used++;
        answer(ok);
        if (ok) begin
            mdl[2] = mdl[1];
            mdl[1] = mdl[0];
            mdl[0] = tmp;
        end
        check_all();
    endtask : do_save
    task do_copy(input int s, input int d, input bit l);
        bit ok;
        d = (d == 4) ? 5 : d;
        ok = accept(s < 6 && d < 6);
        @(posedge clk);
        u_cas_host.copy(s[2:0], d[2:0], l, 1'($urandom_range(1)));
        if (ok) used++;
        answer(ok);
        if (ok) begin
            tmp = mdl[s];
            if (d == 0) begin
                mdl[2] = mdl[1];
                mdl[1] = mdl[0];
            end
            mdl[d] = tmp;
        end
        check_all();
    endtask : do_copy

    initial begin
        {clk, nrst, stage_wr, stage_addr, stage_data, rd_area, rd_addr} = '0;
        act_addr = 4'hf;
        {fails, checks, cyc, used} = '0;
        foreach (mdl[a, i]) mdl[a][i] = 16'h0;
        void'($urandom(32'hec1f));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        check_all();
        do_save();
        do_copy(0, 3, 1'b1);
        repeat (3) do_save();
        do_copy(3, 0, 1'b0);
        do_copy(1, 0, 1'b1);
        do_copy($urandom_range(5), 5, $urandom_range(1));
        do_copy(7, 1, 1'b0);
        do_save();
        @(posedge clk);
        u_cas_host.compact();
        used = 0;
        answer(1'b1);
        check_all();
        do_save();
        print_verdict();
    end
endmodule : cas_store_tb_top

bind cas_store cas_store_chk #(.SLOTS(SLOTS), .AW(AW)) u_cas_store_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_stage_wr(i_stage_wr),
    .i_stage_addr(i_stage_addr), .i_stage_data(i_stage_data),
    .i_cal_store_cmd(i_cal_store_cmd), .i_copy_cmd(i_copy_cmd),
    .i_flash_compact_cmd(i_flash_compact_cmd), .i_act_addr(i_act_addr),
    .o_active_data(o_active_data), .o_done(o_done), .o_err(o_err),
    .o_slots_used(o_slots_used));
